// ===== verilog/srcr_pkg.sv
//
// Purpose: Shared constants for the timing-reference configuration register bank.
// Assumes: Byte-wide registers on a 15-bit serial address space.
// Notes:   Multi-byte registers place the least significant byte at the lowest address.
//
package srcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register addresses.
  localparam int          ADDR_W          = 15;
  localparam logic [14:0] ADR_MAKER_LO    = 15'h000C;
  localparam logic [14:0] ADR_MAKER_HI    = 15'h000D;
  localparam logic [14:0] ADR_USER_CFG    = 15'h0010;
  localparam logic [14:0] ADR_SYNC_CTRL   = 15'h0029;
  localparam logic [14:0] ADR_CLK_IN_CTRL = 15'h002A;
  localparam logic [14:0] ADR_POS_LO      = 15'h002C;
  localparam logic [14:0] ADR_POS_MID     = 15'h002D;
  localparam logic [14:0] ADR_POS_HI      = 15'h002E;
  localparam logic [14:0] ADR_STEP        = 15'h0001;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0]  RST_USER_CFG    = 8'h00;
  localparam logic [7:0]  RST_SYNC_CTRL   = 8'h80;
  localparam logic [7:0]  RST_CLK_IN_CTRL = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int          ADDR_HOLD_BIT   = 0;
  localparam int          PROC_ON_BIT     = 6;
  localparam int          RECV_ON_BIT     = 5;
  localparam int          FINE_BIT        = 4;
  localparam int          SEL_MSB         = 3;
  localparam int          SEL_LSB         = 0;
  localparam int          INVERT_BIT      = 0;
  localparam int          SYNC_PECL_BIT   = 1;
  localparam int          DEV_PECL_BIT    = 2;
  localparam int          RW_BIT          = 14;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Frame and timing-path counts.
  localparam logic [4:0]  HDR_LAST_BIT    = 5'h0F;
  localparam logic [4:0]  BYTE_LAST_BIT   = 5'h07;
  localparam int          POS_W           = 24;
  localparam int          HIST_W          = 48;

  typedef enum logic [0:0] {
    SPI_HDR  = 1'b0,
    SPI_DATA = 1'b1
  } srcr_spi_t;

endpackage : srcr_pkg

// ===== verilog/srcr_sync_path.sv
//
// Purpose: Timing-reference receive path with polarity, delay tap and capture position.
// Assumes: The reference input is asynchronous to clock.
// Notes:   Coarse mode uses every second history stage as one delay step.
//
`timescale 1ns/1ps
module srcr_sync_path (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sysref_in,
  input  wire logic        rx_on,
  input  wire logic        proc_on,
  input  wire logic        fine,
  input  wire logic [3:0]  sel,
  input  wire logic        invert,
  output logic             sync_event,
  output logic [23:0]      capture_pos
);

  logic                        sr_m_ff;
  logic                        sr_s_ff;
  logic [srcr_pkg::HIST_W-1:0] hist_ff;
  logic                        tap_d_ff;
  logic                        event_ff;
  logic [srcr_pkg::POS_W-1:0]  pos_ff;
  wire                         rx_lvl;
  wire  [5:0]                  tap_idx;
  wire                         tap;
  wire                         edge_now;
  wire  [srcr_pkg::POS_W-1:0]  pos_win;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    sr_m_ff <= sysref_in;
    sr_s_ff <= sr_m_ff;
  end

  assign rx_lvl   = rx_on & (sr_s_ff ^ invert);
  assign tap_idx  = fine ? {2'h0, sel} : {1'h0, sel, 1'h0};
  assign tap      = hist_ff[tap_idx];
  assign edge_now = rx_lvl & ~hist_ff[0];

  genvar i;
  generate
    for (i = 0; i < srcr_pkg::POS_W; i++) begin : g_pos
      assign pos_win[i] = fine ? hist_ff[i] : hist_ff[2*i];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      hist_ff  <= '0;
      tap_d_ff <= 1'b0;
      event_ff <= 1'b0;
      pos_ff   <= '0;
    end else begin
      hist_ff  <= {hist_ff[srcr_pkg::HIST_W-2:0], rx_lvl};
      tap_d_ff <= tap;
      event_ff <= proc_on & tap & ~tap_d_ff;
      if (edge_now) begin
        pos_ff <= pos_win;
      end
    end
  end

  assign sync_event  = event_ff;
  assign capture_pos = pos_ff;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_proc_gate: assert property (sync_event |-> $past(proc_on) && $past(tap))
    else $error("Reference event raised while processor was off.");

  a_pos_needs_rx: assert property ($changed(capture_pos) |-> $past(rx_on))
    else $error("Capture position changed with receiver off.");

  a_invert_path: assert property (rx_on |=> hist_ff[0] == ($past(sr_s_ff) ^ $past(invert)))
    else $error("Received level does not follow polarity control.");

endmodule : srcr_sync_path

// ===== verilog/srcr_config_regs.sv
//
// Purpose: Serial-port configuration registers for the timing-reference path.
// Assumes: Four-wire serial port, mode 0, frame of read flag, 15-bit address, data bytes.
// Notes:   Port pins are sampled by clock; the serial clock must be at most clock / 6.
`timescale 1ns/1ps
module srcr_config_regs #(
  // Value is arbitrary.
  parameter logic [15:0] MAKER_CODE = 16'h5A3C
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  input  wire logic        sysref_in,
  input  wire logic        addr_ascend,
  output logic             sync_receiver_on,
  output logic             sync_event_processor_on,
  output logic             window_fine_steps,
  output logic [3:0]       sync_delay_select,
  output logic             sync_polarity_invert,
  output logic             device_clock_pecl_mode,
  output logic             sync_input_pecl_mode,
  output logic             sync_event
);

  logic                sclk_m_ff;
  logic                sclk_s_ff;
  logic                sclk_d_ff;
  logic                cs_m_ff;
  logic                cs_s_ff;
  logic                sdi_m_ff;
  logic                sdi_s_ff;
  srcr_pkg::srcr_spi_t state_ff;
  logic [4:0]          cnt_ff;
  logic [14:0]         shift_ff;
  logic                rd_ff;
  logic [14:0]         addr_ff;
  logic [7:0]          tx_ff;
  logic                sdo_ff;
  logic [7:0]          user_cfg_ff;
  logic [7:0]          sync_ctrl_ff;
  logic [7:0]          clk_in_ff;
  wire  [23:0]         capture_pos;
  wire                 active;
  wire                 rise;
  wire                 fall;
  wire                 hdr_done;
  wire                 byte_done;
  wire                 wr_commit;
  wire  [7:0]          rx_byte;
  wire  [14:0]         hdr_addr;
  wire  [14:0]         step_addr;
  wire  [14:0]         load_addr;
  wire                 addr_hold;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read data for one byte address.
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] d;
    d = srcr_pkg::RD_UNMAPPED;
    case (a)
      srcr_pkg::ADR_MAKER_LO:    d = MAKER_CODE[7:0];
      srcr_pkg::ADR_MAKER_HI:    d = MAKER_CODE[15:8];
      srcr_pkg::ADR_USER_CFG:    d = user_cfg_ff;
      srcr_pkg::ADR_SYNC_CTRL:   d = sync_ctrl_ff;
      srcr_pkg::ADR_CLK_IN_CTRL: d = clk_in_ff;
      srcr_pkg::ADR_POS_LO:      d = capture_pos[7:0];
      srcr_pkg::ADR_POS_MID:     d = capture_pos[15:8];
      srcr_pkg::ADR_POS_HI:      d = capture_pos[23:16];
      default:                   d = srcr_pkg::RD_UNMAPPED;
    endcase
    return d;
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the third serial clock stage is for edge detection.
  always_ff @(posedge clock) begin
    sclk_m_ff <= spi_sclk;
    sclk_s_ff <= sclk_m_ff;
    sclk_d_ff <= sclk_s_ff;
    cs_m_ff   <= spi_cs_n;
    cs_s_ff   <= cs_m_ff;
    sdi_m_ff  <= spi_sdi;
    sdi_s_ff  <= sdi_m_ff;
  end

  assign active    = ~cs_s_ff;
  assign rise      = active & sclk_s_ff & ~sclk_d_ff;
  assign fall      = active & ~sclk_s_ff & sclk_d_ff;
  assign hdr_done  = rise && (state_ff == srcr_pkg::SPI_HDR) && (cnt_ff == srcr_pkg::HDR_LAST_BIT);
  assign byte_done = rise && (state_ff == srcr_pkg::SPI_DATA)
                     && (cnt_ff == srcr_pkg::BYTE_LAST_BIT);
  assign wr_commit = byte_done & ~rd_ff;
  assign rx_byte   = {shift_ff[6:0], sdi_s_ff};
  assign hdr_addr  = {shift_ff[13:0], sdi_s_ff};
  assign addr_hold = user_cfg_ff[srcr_pkg::ADDR_HOLD_BIT];
  assign step_addr = addr_hold   ? addr_ff :
                     addr_ascend ? addr_ff + srcr_pkg::ADR_STEP : addr_ff - srcr_pkg::ADR_STEP;
  assign load_addr = hdr_done ? hdr_addr : step_addr;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Frame sequencing.
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      state_ff <= srcr_pkg::SPI_HDR;
      cnt_ff   <= 5'h00;
    end else if (hdr_done || byte_done) begin
      state_ff <= srcr_pkg::SPI_DATA;
      cnt_ff   <= 5'h00;
    end else if (rise) begin
      cnt_ff   <= cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shift_ff <= '0;
      rd_ff    <= 1'b0;
      addr_ff  <= '0;
    end else begin
      if (rise) begin
        shift_ff <= hdr_addr;
      end
      if (hdr_done) begin
        rd_ff <= shift_ff[srcr_pkg::RW_BIT];
      end
      if (hdr_done || byte_done) begin
        addr_ff <= load_addr;
      end
    end
  end

  // Read data shifts out most significant bit first on falling serial clock edges.
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      tx_ff  <= 8'h00;
      sdo_ff <= 1'b0;
    end else if (hdr_done || byte_done) begin
      tx_ff  <= rd_byte(load_addr);
    end else if (fall) begin
      sdo_ff <= tx_ff[7];
      tx_ff  <= {tx_ff[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Writable registers; reserved bits are stored as written.
  always_ff @(posedge clock) begin
    if (rst) begin
      user_cfg_ff  <= srcr_pkg::RST_USER_CFG;
      sync_ctrl_ff <= srcr_pkg::RST_SYNC_CTRL;
      clk_in_ff    <= srcr_pkg::RST_CLK_IN_CTRL;
    end else if (wr_commit) begin
      // No write path to capture position.
      case (addr_ff)
        srcr_pkg::ADR_USER_CFG:    user_cfg_ff  <= rx_byte;
        srcr_pkg::ADR_SYNC_CTRL:   sync_ctrl_ff <= rx_byte;
        srcr_pkg::ADR_CLK_IN_CTRL: clk_in_ff    <= rx_byte;
        default:                   user_cfg_ff  <= user_cfg_ff;
      endcase
    end
  end

  assign spi_sdo                 = sdo_ff;
  assign sync_receiver_on        = sync_ctrl_ff[srcr_pkg::RECV_ON_BIT];
  assign sync_event_processor_on = sync_ctrl_ff[srcr_pkg::PROC_ON_BIT];
  assign window_fine_steps       = sync_ctrl_ff[srcr_pkg::FINE_BIT];
  assign sync_delay_select       = sync_ctrl_ff[srcr_pkg::SEL_MSB:srcr_pkg::SEL_LSB];
  assign sync_polarity_invert    = clk_in_ff[srcr_pkg::INVERT_BIT];
  assign device_clock_pecl_mode  = clk_in_ff[srcr_pkg::DEV_PECL_BIT];
  assign sync_input_pecl_mode    = clk_in_ff[srcr_pkg::SYNC_PECL_BIT];

  ////////////////////////////////////////////////////////////////////////////////////////////////
  srcr_sync_path u_path (
    .clock       (clock),
    .rst         (rst),
    .sysref_in   (sysref_in),
    .rx_on       (sync_receiver_on),
    .proc_on     (sync_event_processor_on),
    .fine        (window_fine_steps),
    .sel         (sync_delay_select),
    .invert      (sync_polarity_invert),
    .sync_event  (sync_event),
    .capture_pos (capture_pos)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_byte_step;
    byte_done && !addr_hold;
  endsequence

  a_maker_fixed: assert property ((hdr_done || byte_done) && load_addr == srcr_pkg::ADR_MAKER_LO
                                  |=> tx_ff == MAKER_CODE[7:0])
    else $error("Maker code low byte not loaded for read.");

  a_addr_hold: assert property (byte_done && addr_hold |=> $stable(addr_ff))
    else $error("Address moved while hold was set.");

  a_addr_up: assert property (s_byte_step ##0 addr_ascend
                              |=> addr_ff == $past(addr_ff) + srcr_pkg::ADR_STEP)
    else $error("Address did not increment.");

  a_addr_down: assert property (s_byte_step ##0 !addr_ascend
                                |=> addr_ff == $past(addr_ff) - srcr_pkg::ADR_STEP)
    else $error("Address did not decrement.");

  a_ctrl_on_byte: assert property ($changed(sync_ctrl_ff) |-> $past(wr_commit))
    else $error("Control register changed without a completed byte.");

  a_pos_readonly: assert property (wr_commit && addr_ff >= srcr_pkg::ADR_POS_LO
                                   && addr_ff <= srcr_pkg::ADR_POS_HI
                                   |=> $stable(sync_ctrl_ff) && $stable(clk_in_ff)
                                       && $stable(user_cfg_ff))
    else $error("Write to capture position disturbed a register.");

endmodule : srcr_config_regs

// ===== sim/srcr_spi_host.sv
// Purpose: Serial host model that drives frames into the register bank.
// Assumes: Mode 0, MSB first, 400 ns serial period, called on a falling clock edge.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
module srcr_spi_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sends nb bits of header and data; collects the bits after the header.
  task automatic frame(input logic [47:0] bits, input int nb, output logic [31:0] rd);
    int i;
    rd = 32'h0;
    #200 cs_n = 1'b0;
    for (i = 0; i < nb; i++) begin
      sdi = bits[47-i];
      #200 sclk = 1'b1;
      #200;
      if (i > 15) rd = {rd[30:0], sdo};
      sclk = 1'b0;
    end
    sdi = ~sdi;
    #200 cs_n = 1'b1;
    #400;
  endtask : frame
endmodule : srcr_spi_host

// ===== sim/tb_sysref_spi_config_regs.sv
// Purpose: Self-checking bench for the timing-reference register bank.
// Assumes: Bench inputs change at the falling clock edge.
// Notes:   A register model predicts every read and every control output.
`timescale 1ns/1ps
module tb_sysref_spi_config_regs;
  localparam logic [15:0] MAKER = 16'h1E87; // Value is arbitrary.
  logic        clock, rst, sysref_in, addr_ascend;
  logic        sclk, cs_n, sdi, sdo, rx_on, proc_on, fine, inv, dpecl, specl, sync_event;
  logic [3:0]  sel;
  int          num_errors, checks_done, cycles, events, exp_ev, k, j, v;
  int          mdl [0:63];

  srcr_spi_host i_srcr_spi_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  srcr_config_regs #(.MAKER_CODE(MAKER)) i_srcr_config_regs (
    .clock(clock), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo(sdo), .sysref_in(sysref_in), .addr_ascend(addr_ascend),
    .sync_receiver_on(rx_on), .sync_event_processor_on(proc_on),
    .window_fine_steps(fine), .sync_delay_select(sel), .sync_polarity_invert(inv),
    .device_clock_pecl_mode(dpecl), .sync_input_pecl_mode(specl), .sync_event(sync_event));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  always @(posedge clock) begin
    cycles++;
    if (sync_event === 1'b1) events++;
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic int rd_exp(int a);
    case (a)
      12: return MAKER[7:0];
      13: return MAKER[15:8];
      16, 41, 42, 44, 45, 46: return mdl[a];
      default: return 0;
    endcase
  endfunction : rd_exp

  task automatic chk_out;
    check({proc_on, rx_on, fine, sel}, mdl[41][6:0]);
    check({dpecl, specl, inv}, mdl[42][2:0]);
  endtask : chk_out

  task automatic xfer(input logic rd, input int a, input int n, input logic [31:0] wd);
    logic [31:0] got, exp;
    int p, i;
    p = a;
    exp = 0;
    for (i = 0; i < n; i++) begin
      if (rd) exp = (exp << 8) | rd_exp(p);
      else if (p == 16 || p == 41 || p == 42) mdl[p] = (wd >> (24 - 8 * i)) & 255;
      if (mdl[16][0] == 0) p = addr_ascend ? p + 1 : p - 1;
    end
    i_srcr_spi_host.frame({rd, a[14:0], wd}, 16 + 8 * n, got);
    if (rd) check(got, exp);
    chk_out();
  endtask : xfer

  task automatic wr(input int a, input int d);
    xfer(1'b0, a, 1, d << 24);
  endtask : wr

  task automatic pred(input logic lv, input logic inv_new);
    if (mdl[41][6:5] == 3 && (sysref_in ^ mdl[42][0]) == 0 && (lv ^ inv_new) == 1) exp_ev++;
  endtask : pred

  task automatic ref_level(input logic lv);
    pred(lv, mdl[42][0]);
    @(negedge clock) sysref_in = lv;
    repeat (40) @(negedge clock);
    check(events, exp_ev);
  endtask : ref_level

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    sysref_in = 1'b0;
    addr_ascend = 1'b1;
    void'($urandom(45));
    mdl[16] = 0;
    mdl[41] = 8'h80;
    mdl[42] = 0;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    chk_out();
    xfer(1'b1, 8'h29, 3, 0);
    xfer(1'b1, 8'h10, 1, 0);
    xfer(1'b1, 8'h0C, 2, 0);
    xfer(1'b0, 8'h0C, 2, 32'hFFFF0000);
    xfer(1'b1, 8'h0C, 2, 0);
    xfer(1'b0, 8'h2C, 3, 32'hFFFFFF00);
    xfer(1'b1, 8'h2C, 3, 0);
    for (k = 0; k < 4; k++) begin
      v = $urandom;
      pred(sysref_in, v[0]);
      wr(42, v & 7);
      wr(41, 8'hA0 | v[12:8]);
      wr(41, 8'hE0 | v[20:16]);
      xfer(1'b1, 8'h29, 2, 0);
    end
    xfer(1'b0, 8'h29, 2, 32'hB5060000);
    @(negedge clock) addr_ascend = 1'b0;
    xfer(1'b0, 8'h2A, 2, 32'h01AC0000);
    xfer(1'b1, 8'h2A, 2, 0);
    @(negedge clock) addr_ascend = 1'b1;
    wr(16, 1);
    xfer(1'b0, 8'h29, 3, 32'hA1A2A700);
    xfer(1'b1, 8'h29, 2, 0);
    wr(16, 0);
    i_srcr_spi_host.frame({1'b0, 15'h0029, 32'h0}, 20, v);
    chk_out();
    for (j = 0; j < 2; j++) begin
      v = ($urandom % 16) | (j << 4);
      wr(41, 8'hA0 | v);
      ref_level(j[0]);
      wr(42, j);
      wr(41, 8'hE0 | v);
      repeat (4) ref_level(~sysref_in);
      wr(41, 8'hA0 | v);
      ref_level(~sysref_in);
    end
    // capture position in both step sizes
    for (j = 0; j < 2; j++) begin
      k = 1 + $urandom % 20;
      v = (32'hFFFFFF << (j ? k : (k + 1) / 2)) & 32'hFFFFFF;
      mdl[44] = v & 255;
      mdl[45] = (v >> 8) & 255;
      mdl[46] = (v >> 16) & 255;
      wr(42, 0);
      wr(41, 8'hA0 | (j << 4));
      @(negedge clock) sysref_in = 1'b1;
      repeat (60) @(negedge clock);
      sysref_in = 1'b0;
      repeat (k) @(negedge clock);
      sysref_in = 1'b1;
      xfer(1'b1, 8'h2C, 3, 0);
    end
    complete_run();
  end
endmodule : tb_sysref_spi_config_regs
